/* rtl/tlic_core.sv */
// two-level interrupt controller with an AXI4-Lite register slave.
// assumes a core on the same clock that accepts a vector with vector_ack
// and reports the return-from-interrupt operation with a one-cycle pulse.
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
module tlic_core
  import tlic_pkg::*;
(
  input wire logic aclk, // 100 MHz clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [tlic_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [tlic_pkg::ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [3:0] ext_pin, // external interrupt pins 0..3, async
  input wire logic [3:0] pchg_pin, // port change pins, async
  input wire logic tmr0_event, // timer0 overflow pulse
  input wire logic [7:0] periph_event, // peripheral event pulses
  output logic vector_req, // request to vector
  output logic [15:0] vector_addr, // vector target
  input wire logic vector_ack, // core accepts the vector
  output logic stack_push, // push return address now
  input wire logic return_op, // return-from-interrupt executed
  output logic [7:0] pullup_en, // port pull-up enables
  output logic irq_out // level interrupt to the system
);
  import tlic_pkg::*;

  typedef struct packed {
    logic [7:0] reset_ctl;
    logic [7:0] irq_ctl;
    logic [7:0] irq_ctl2;
    logic [7:0] irq_ctl3;
    logic [7:0] per_flag;
    logic [7:0] per_en;
    logic [7:0] per_prio;
    logic [7:0] port_latch;
    logic [2:0] evt_stat;
    logic [2:0] evt_mask;
    logic in_high;
    logic in_low;
    logic req;
    logic vec_high;
    logic [15:0] addr;
    logic [3:0] ext_s1;
    logic [3:0] ext_s2;
    logic [3:0] ext_prev;
    logic [3:0] chg_s1;
    logic [3:0] chg_s2;
    logic [3:0] chg_prev;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
  } tlic_state_type;

  tlic_state_type st;
  tlic_state_type next_st;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFS_RESET_CTL) || (a == OFS_IRQ_CTL) || (a == OFS_IRQ_CTL2) ||
             (a == OFS_IRQ_CTL3) || (a == OFS_PER_FLAG) || (a == OFS_PER_EN) ||
             (a == OFS_PER_PRIO) || (a == OFS_SERVICE) || (a == OFS_EVT_STAT) ||
             (a == OFS_EVT_MASK) || (a == OFS_PORT_LATCH);
  endfunction

  function automatic logic [7:0] read_reg(input tlic_state_type s, input logic [7:0] a);
    unique case (a)
      OFS_RESET_CTL: read_reg = s.reset_ctl;
      OFS_IRQ_CTL: read_reg = s.irq_ctl;
      OFS_IRQ_CTL2: read_reg = s.irq_ctl2;
      OFS_IRQ_CTL3: read_reg = s.irq_ctl3;
      OFS_PER_FLAG: read_reg = s.per_flag;
      OFS_PER_EN: read_reg = s.per_en;
      OFS_PER_PRIO: read_reg = s.per_prio;
      OFS_SERVICE: read_reg = {5'h00, s.vec_high, s.in_high, s.in_low};
      OFS_EVT_STAT: read_reg = {5'h00, s.evt_stat};
      OFS_EVT_MASK: read_reg = {5'h00, s.evt_mask};
      OFS_PORT_LATCH: read_reg = s.port_latch;
      default: read_reg = 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // source vectors: bit 0 tmr0, 1 ext0, 2 port change, 3..5 ext1..3, 6..13 peripherals
  logic [13:0] src_flag;
  logic [13:0] src_en;
  logic [13:0] src_prio;
  logic [13:0] src_act;
  logic [3:0] ext_edge;
  logic pchg_event;
  logic priority_levels_enable;
  logic want_high;
  logic want_low;
  logic want_compat;
  logic accept;
  logic aw_hs;
  logic w_hs;
  logic do_write;
  logic [7:0] wr_addr;
  logic [7:0] wr_val;
  logic wr_en0;

  assign priority_levels_enable = st.reset_ctl[BIT_PRIO_LEVELS];
  assign src_flag = {st.per_flag, st.irq_ctl3[2:0], st.irq_ctl[BIT_PCHG_FLAG],
                     st.irq_ctl[BIT_EXT0_FLAG], st.irq_ctl[BIT_TMR0_FLAG]};
  assign src_en = {st.per_en, st.irq_ctl3[5:3], st.irq_ctl[BIT_PCHG_EN],
                   st.irq_ctl[BIT_EXT0_EN], st.irq_ctl[BIT_TMR0_EN]};
  // ext0 has no priority bit and always belongs to the high group
  assign src_prio = {st.per_prio, st.irq_ctl2[1], st.irq_ctl3[7], st.irq_ctl3[6],
                     st.irq_ctl2[0], 1'b1, st.irq_ctl2[2]};
  assign src_act = src_flag & src_en;

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (st.irq_ctl2[BIT_EDGE0-i])
        ext_edge[i] = st.ext_s2[i] & ~st.ext_prev[i];
      else
        ext_edge[i] = ~st.ext_s2[i] & st.ext_prev[i];
    end
  end
  assign pchg_event = |(st.chg_s2 ^ st.chg_prev);

  assign want_high = st.irq_ctl[BIT_GLOBAL_EN] & |(src_act & src_prio);
  // low group waits while high service runs
  assign want_low = st.irq_ctl[BIT_PERIPH_EN] & |(src_act & ~src_prio) & ~st.in_high;
  assign want_compat = st.irq_ctl[BIT_GLOBAL_EN] &
                       (|src_act[5:0] | (st.irq_ctl[BIT_PERIPH_EN] & |src_act[13:6]));

  assign accept = st.req & vector_ack;
  // return address pushed as the vector is taken
  assign stack_push = accept;
  assign vector_req = st.req;
  assign vector_addr = st.addr;

  assign aw_hs = s_axi_awvalid & s_axi_awready;
  assign w_hs = s_axi_wvalid & s_axi_wready;
  assign s_axi_awready = ~st.aw_got & ~st.bvalid;
  assign s_axi_wready = ~st.w_got & ~st.bvalid;
  assign s_axi_arready = ~st.rvalid;
  assign do_write = (st.aw_got | aw_hs) & (st.w_got | w_hs) & ~st.bvalid;
  assign wr_addr = st.aw_got ? st.awaddr : s_axi_awaddr;
  assign wr_val = st.w_got ? st.wdata : s_axi_wdata[7:0];
  assign wr_en0 = do_write & (st.w_got ? st.wstrb0 : s_axi_wstrb[0]);

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_st = st;
    // two-stage pin synchronisers, then edge detect
    next_st.ext_s1 = ext_pin;
    next_st.ext_s2 = st.ext_s1;
    next_st.ext_prev = st.ext_s2;
    next_st.chg_s1 = pchg_pin;
    next_st.chg_s2 = st.chg_s1;
    next_st.chg_prev = st.chg_s2;

    // register writes; a write that lands with an event still leaves the flag set
    if (wr_en0)
    begin
      unique case (wr_addr)
        OFS_RESET_CTL: next_st.reset_ctl = wr_val & 8'h80;
        OFS_IRQ_CTL: next_st.irq_ctl = wr_val;
        OFS_IRQ_CTL2: next_st.irq_ctl2 = wr_val;
        OFS_IRQ_CTL3: next_st.irq_ctl3 = wr_val;
        OFS_PER_FLAG: next_st.per_flag = wr_val;
        OFS_PER_EN: next_st.per_en = wr_val;
        OFS_PER_PRIO: next_st.per_prio = wr_val;
        OFS_EVT_STAT: next_st.evt_stat = st.evt_stat & ~wr_val[2:0];
        OFS_EVT_MASK: next_st.evt_mask = wr_val[2:0];
        OFS_PORT_LATCH: next_st.port_latch = wr_val;
        default: next_st.port_latch = st.port_latch;
      endcase
    end

    // events set flags whatever the enables
    if (tmr0_event)
      next_st.irq_ctl[BIT_TMR0_FLAG] = 1'b1;
    if (ext_edge[0])
      next_st.irq_ctl[BIT_EXT0_FLAG] = 1'b1;
    if (pchg_event)
      next_st.irq_ctl[BIT_PCHG_FLAG] = 1'b1;
    // one edge sets one flag, held until software clears it
    next_st.irq_ctl3[2:0] = next_st.irq_ctl3[2:0] | ext_edge[3:1];
    next_st.per_flag = next_st.per_flag | periph_event;

    // accepting clears the enable that admitted the request
    if (accept)
    begin
      if (priority_levels_enable && st.vec_high)
      begin
        next_st.irq_ctl[BIT_GLOBAL_EN] = 1'b0;
        next_st.in_high = 1'b1;
        next_st.evt_stat[EVT_HIGH_VEC] = 1'b1;
      end
      else if (priority_levels_enable)
      begin
        next_st.irq_ctl[BIT_PERIPH_EN] = 1'b0;
        next_st.in_low = 1'b1;
        next_st.evt_stat[EVT_LOW_VEC] = 1'b1;
      end
      else
      begin
        next_st.irq_ctl[BIT_GLOBAL_EN] = 1'b0;
        next_st.in_high = 1'b1;
        next_st.evt_stat[EVT_HIGH_VEC] = 1'b1;
      end
    end
    // return re-opens the group it leaves
    else if (return_op)
    begin
      next_st.evt_stat[EVT_RETURN] = 1'b1;
      if (!priority_levels_enable || st.in_high)
      begin
        next_st.irq_ctl[BIT_GLOBAL_EN] = 1'b1;
        next_st.in_high = 1'b0;
      end
      else
      begin
        next_st.irq_ctl[BIT_PERIPH_EN] = 1'b1;
        next_st.in_low = 1'b0;
      end
    end

    // request raised the cycle after all conditions hold; a pin edge
    // reaches vector_req after two sync stages, edge detect and flag: four cycles
    if (accept)
    begin
      next_st.req = 1'b0;
    end
    else if (priority_levels_enable)
    begin
      // high group outranks a running low routine
      next_st.req = want_high | want_low;
      next_st.vec_high = want_high;
      next_st.addr = want_high ? VEC_HIGH : VEC_LOW;
    end
    else
    begin
      next_st.req = want_compat;
      next_st.vec_high = 1'b1;
      next_st.addr = VEC_HIGH;
    end

    // axi write side
    if (aw_hs && !do_write)
    begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (w_hs && !do_write)
    begin
      next_st.w_got = 1'b1;
      next_st.wdata = s_axi_wdata[7:0];
      next_st.wstrb0 = s_axi_wstrb[0];
    end
    if (do_write)
    begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (st.bvalid && s_axi_bready)
      next_st.bvalid = 1'b0;

    // axi read side
    if (s_axi_arvalid && !st.rvalid)
    begin
      next_st.rvalid = 1'b1;
      next_st.rdata = read_reg(st, s_axi_araddr);
      next_st.rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (st.rvalid && s_axi_rready)
      next_st.rvalid = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st <= '0;
      st.reset_ctl <= RST_RESET_CTL;
      st.irq_ctl <= RST_IRQ_CTL;
      st.irq_ctl2 <= RST_IRQ_CTL2;
      st.irq_ctl3 <= RST_IRQ_CTL3;
      st.per_flag <= RST_ZERO;
      st.per_en <= RST_ZERO;
      st.per_prio <= RST_PER_PRIO;
      st.port_latch <= RST_ZERO;
      st.addr <= VEC_HIGH;
    end
    else
      st <= next_st;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pull-ups follow latch unless disabled
  assign pullup_en = st.irq_ctl2[BIT_PULLUP_DIS] ? 8'h00 : st.port_latch;
  assign irq_out = |(st.evt_stat & st.evt_mask);

  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rresp = st.rresp;
  assign s_axi_rdata = {24'h000000, st.rdata};

  ////////////////////////////////////////////////////////////////////////////
  chk_vector_compat: assert property (@(posedge aclk) disable iff (!aresetn)
    (st.req && !priority_levels_enable && !$past(priority_levels_enable)) |-> (vector_addr == 16'h0008))
    else $error("compat vector not at 0008h");

  chk_vector_level: assert property (@(posedge aclk) disable iff (!aresetn)
    (st.req && $past(priority_levels_enable)) |-> (vector_addr == (st.vec_high ? 16'h0008 : 16'h0018)))
    else $error("priority vector does not match level");

  chk_accept_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (accept && !priority_levels_enable && !wr_en0) |=> !st.irq_ctl[BIT_GLOBAL_EN] && !st.req)
    else $error("global enable not cleared on accept");

  chk_return_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    (return_op && !accept && !priority_levels_enable && !wr_en0) |=> st.irq_ctl[BIT_GLOBAL_EN])
    else $error("return did not restore global enable");

  chk_low_held: assert property (@(posedge aclk) disable iff (!aresetn)
    (priority_levels_enable && st.in_high && !accept) |=> !(st.req && !st.vec_high))
    else $error("low request raised during high service");

  chk_high_preempt: assert property (@(posedge aclk) disable iff (!aresetn)
    (priority_levels_enable && st.in_low && want_high && !accept) |=> (st.req && st.vec_high))
    else $error("high request did not preempt low routine");

  chk_pin_latency: assert property (@(posedge aclk) disable iff (!aresetn)
    (priority_levels_enable && $rose(ext_edge[0]) && st.irq_ctl[BIT_EXT0_EN] && st.irq_ctl[BIT_GLOBAL_EN]
     && !st.req && !vector_ack && !wr_en0) |-> ##2 st.req)
    else $error("pin event not vectored in time");

  chk_flag_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    ext_edge[1] |=> st.irq_ctl3[0])
    else $error("edge did not set its flag");

  chk_pullup_off: assert property (@(posedge aclk) disable iff (!aresetn)
    st.irq_ctl2[BIT_PULLUP_DIS] |-> (pullup_en == 8'h00))
    else $error("pull-up enabled while disabled");

  chk_push_once: assert property (@(posedge aclk) disable iff (!aresetn)
    stack_push |=> !stack_push)
    else $error("stack push repeated");
endmodule

/* rtl/tlic_pkg.sv */
// constants for the two-level interrupt controller: register offsets,
// field positions, reset values and vector addresses.
// assumes a 32-bit AXI4-Lite bus with byte addresses; registers are 8 bits in the low lane.
package tlic_pkg;
  localparam int unsigned ADDR_W = 8;
  // register byte offsets
  localparam logic [7:0] OFS_RESET_CTL = 8'h00;
  localparam logic [7:0] OFS_IRQ_CTL = 8'h04;
  localparam logic [7:0] OFS_IRQ_CTL2 = 8'h08;
  localparam logic [7:0] OFS_IRQ_CTL3 = 8'h0C;
  localparam logic [7:0] OFS_PER_FLAG = 8'h10;
  localparam logic [7:0] OFS_PER_EN = 8'h14;
  localparam logic [7:0] OFS_PER_PRIO = 8'h18;
  localparam logic [7:0] OFS_SERVICE = 8'h1C;
  localparam logic [7:0] OFS_EVT_STAT = 8'h20;
  localparam logic [7:0] OFS_EVT_MASK = 8'h24;
  localparam logic [7:0] OFS_PORT_LATCH = 8'h28;
  // reset values
  localparam logic [7:0] RST_RESET_CTL = 8'h00;
  localparam logic [7:0] RST_IRQ_CTL = 8'h00;
  localparam logic [7:0] RST_IRQ_CTL2 = 8'hFF;
  localparam logic [7:0] RST_IRQ_CTL3 = 8'hC0;
  localparam logic [7:0] RST_PER_PRIO = 8'hFF;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // reset control register
  localparam int unsigned BIT_PRIO_LEVELS = 7;
  // irq control register
  localparam int unsigned BIT_GLOBAL_EN = 7;
  localparam int unsigned BIT_PERIPH_EN = 6;
  localparam int unsigned BIT_TMR0_EN = 5;
  localparam int unsigned BIT_EXT0_EN = 4;
  localparam int unsigned BIT_PCHG_EN = 3;
  localparam int unsigned BIT_TMR0_FLAG = 2;
  localparam int unsigned BIT_EXT0_FLAG = 1;
  localparam int unsigned BIT_PCHG_FLAG = 0;
  // irq control two: [7] pull-up disable, [6:3] edge select ext0..ext3, [2:0] prio tmr0/ext3/pchg
  localparam int unsigned BIT_PULLUP_DIS = 7;
  localparam int unsigned BIT_EDGE0 = 6;
  // irq control three: [7:6] prio ext2/ext1, [5:3] enable ext3..1, [2:0] flag ext3..1
  // event status / mask bits
  localparam int unsigned EVT_HIGH_VEC = 0;
  localparam int unsigned EVT_LOW_VEC = 1;
  localparam int unsigned EVT_RETURN = 2;
  localparam logic [2:0] EVT_ALL = 3'h7;
  // vectors
  localparam logic [15:0] VEC_HIGH = 16'h0008;
  localparam logic [15:0] VEC_LOW = 16'h0018;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* tb/tlic_core_model.sv */
// core model: accepts vectors, keeps a return stack depth, issues returns.
// assumes the controller on the same clock; stall and ret_req come from the bench.
`timescale 1ns/1ns
module tlic_core_model
(
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, active low
  input wire logic vector_req, // vector request
  input wire logic [15:0] vector_addr, // vector target
  input wire logic stack_push, // push pulse
  input wire logic stall, // slow core: hold off acceptance
  input wire logic ret_req, // run one return operation
  output logic vector_ack, // accept
  output logic return_op, // return pulse
  output logic [15:0] pc, // program counter
  output logic [3:0] depth // return stack depth
);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      vector_ack <= 1'b0;
      return_op <= 1'b0;
      pc <= 16'h0000;
      depth <= 4'h0;
    end
    else
    begin
      vector_ack <= vector_req & !stall;
      return_op <= ret_req;
      if (stack_push)
      begin
        pc <= vector_addr;
        depth <= depth + 4'h1;
      end
      else if (return_op)
        depth <= depth - 4'h1;
    end
  end
endmodule

/* tb/two_level_irq_controller_test.sv */
// bench for the two-level interrupt controller: registers over AXI4-Lite,
// vectoring in both modes, pin edges, pull-ups and the event interrupt.
// assumes tlic_pkg, tlic_core and tlic_core_model are compiled first.
`timescale 1ns/1ns
module two_level_irq_controller_test;
  import tlic_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, periph_event = 8'h00, pullup_en, rd_v;
  logic [31:0] wdata = 32'h00000000, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, vector_req, vector_ack, stack_push, return_op, irq_out;
  logic [1:0] bresp, rresp, rsp;
  logic [3:0] ext_pin = 4'h0, depth;
  logic stall = 1'b0, ret_req = 1'b0, tmr0_event = 1'b0;
  logic [3:0] pchg_pin = 4'h0;
  logic [15:0] vector_addr, pc;
  int failures = 0, samples_checked = 0, n;
  always #5 aclk = ~aclk;
  tlic_core tlic_core_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_pin(ext_pin),
    .pchg_pin(pchg_pin), .tmr0_event(tmr0_event), .periph_event(periph_event), .vector_req(vector_req),
    .vector_addr(vector_addr), .vector_ack(vector_ack), .stack_push(stack_push), .return_op(return_op),
    .pullup_en(pullup_en), .irq_out(irq_out));
  tlic_core_model tlic_core_model_i (.aclk(aclk), .aresetn(aresetn), .vector_req(vector_req),
    .vector_addr(vector_addr), .stack_push(stack_push), .stall(stall), .ret_req(ret_req),
    .vector_ack(vector_ack), .return_op(return_op), .pc(pc), .depth(depth));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // address and data offered together, each dropped once taken
  // no cycle limit here: only the watchdog ends a wait for the answer
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rd_v = rdata[7:0];
    rsp = rresp;
    rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    chk(rd_v, exp);
  endtask
  // samples at each edge see the value settled before it, so counts run one high
  task automatic wait_req(input int lim);
    n = 0;
    while (vector_req !== 1'b1 && n < lim)
    begin
      @(posedge aclk);
      n++;
    end
  endtask
  task automatic ret();
    @(posedge aclk);
    ret_req <= 1'b1;
    @(posedge aclk);
    ret_req <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask
  task automatic pulse_periph();
    @(posedge aclk);
    periph_event <= 8'h01;
    @(posedge aclk);
    periph_event <= 8'h00;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [7:0] ofs [6];
    logic [7:0] val [6];
    ofs = '{OFS_RESET_CTL, OFS_IRQ_CTL, OFS_IRQ_CTL2, OFS_IRQ_CTL3, OFS_PER_PRIO, OFS_EVT_STAT};
    val = '{RST_RESET_CTL, RST_IRQ_CTL, RST_IRQ_CTL2, RST_IRQ_CTL3, RST_PER_PRIO, RST_ZERO};
    foreach (ofs[i])
      rchk(ofs[i], val[i]);
    chk(rsp, RESP_OKAY);
    rd(8'h40);
    chk(rsp, RESP_SLVERR);
    wr(8'h40, 8'hFF);
    chk(rsp, RESP_SLVERR);
  endtask
  task automatic t_pins();
    wr(OFS_IRQ_CTL2, 8'hDF);
    @(posedge aclk);
    ext_pin[1] <= 1'b1;
    repeat (6) @(posedge aclk);
    rchk(OFS_IRQ_CTL3, 8'hC0);
    ext_pin[1] <= 1'b0;
    ext_pin[2] <= 1'b1;
    repeat (6) @(posedge aclk);
    rchk(OFS_IRQ_CTL3, 8'hC3);
    // pins back to idle so the later reset sees no false edge
    ext_pin[2] <= 1'b0;
    wr(OFS_IRQ_CTL3, 8'hC0);
    rchk(OFS_IRQ_CTL3, 8'hC0);
    // timer pulse and a port toggle there and back, all enables off
    @(posedge aclk);
    pchg_pin <= 4'h1;
    tmr0_event <= 1'b1;
    @(posedge aclk);
    tmr0_event <= 1'b0;
    repeat (6) @(posedge aclk);
    pchg_pin <= 4'h0;
    repeat (6) @(posedge aclk);
    rchk(OFS_IRQ_CTL, 8'h05);
    wr(OFS_IRQ_CTL, 8'h00);
  endtask
  task automatic t_pullup();
    wr(OFS_PORT_LATCH, 8'hA5);
    chk(rsp, RESP_OKAY);
    chk(pullup_en, 8'h00);
    wr(OFS_IRQ_CTL2, 8'h7F);
    chk(pullup_en, 8'hA5);
    wr(OFS_IRQ_CTL2, 8'hFF);
  endtask
  task automatic t_compat();
    pulse_periph();
    rchk(OFS_PER_FLAG, 8'h01);
    wr(OFS_PER_PRIO, 8'h00);
    wr(OFS_PER_EN, 8'h01);
    wr(OFS_EVT_MASK, 8'h01);
    wr(OFS_IRQ_CTL, 8'h80);
    repeat (5) @(posedge aclk);
    chk(vector_req, 1'b0);
    stall <= 1'b1;
    wr(OFS_IRQ_CTL, 8'hC0);
    wait_req(10);
    repeat (5) @(posedge aclk);
    chk({vector_req, depth}, 5'h10);
    chk(vector_addr, VEC_HIGH);
    stall <= 1'b0;
    repeat (4) @(posedge aclk);
    chk({irq_out, depth}, 5'h11);
    rchk(OFS_IRQ_CTL, 8'h40);
    wr(OFS_PER_FLAG, 8'h00);
    ret();
    rchk(OFS_IRQ_CTL, 8'hC0);
    rchk(OFS_EVT_STAT, 8'h05);
    wr(OFS_EVT_MASK, 8'h00);
    chk(irq_out, 1'b0);
    wr(OFS_EVT_STAT, 8'h07);
    rchk(OFS_EVT_STAT, 8'h00);
  endtask
  task automatic t_prio();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    wr(OFS_RESET_CTL, 8'h80);
    wr(OFS_PER_PRIO, 8'h00);
    wr(OFS_PER_EN, 8'h01);
    wr(OFS_IRQ_CTL, 8'hD0);
    @(posedge aclk);
    ext_pin[0] <= 1'b1;
    wait_req(20);
    chk(n, 5);
    chk(vector_addr, VEC_HIGH);
    repeat (4) @(posedge aclk);
    chk({depth, pc}, {4'h1, VEC_HIGH});
    rchk(OFS_IRQ_CTL, 8'h52);
    wr(OFS_IRQ_CTL, 8'h50);
    pulse_periph();
    wait_req(10);
    chk(vector_req, 1'b0);
    ret();
    wait_req(10);
    chk(vector_addr, VEC_LOW);
    chk(vector_req, 1'b1);
    repeat (4) @(posedge aclk);
    rchk(OFS_IRQ_CTL, 8'h90);
    ext_pin[0] <= 1'b0;
    repeat (4) @(posedge aclk);
    ext_pin[0] <= 1'b1;
    wait_req(20);
    chk(vector_addr, VEC_HIGH);
    repeat (4) @(posedge aclk);
    chk(depth, 4'h2);
    rchk(OFS_SERVICE, 8'h03);
    wr(OFS_PER_FLAG, 8'h00);
    wr(OFS_IRQ_CTL, 8'h10);
    ret();
    ret();
    rchk(OFS_IRQ_CTL, 8'hD0);
    chk(vector_req, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_pins();
    t_pullup();
    t_compat();
    t_prio();
    test_done();
  end
  initial
  begin
    #100000;
    failures++;
    test_done();
  end
endmodule
